// File: inc/tmr_pkg.sv
// shared constants and carrier types for the 16-bit timer/event counter
package tmr_pkg;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CC_RST = 16'h0000;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_EDGE_CLR = 2'h2;
    localparam logic [1:0] MODE_MATCH_CLR = 2'h3;

    // one-hot counter operating state
    typedef enum logic [3:0] {
        TMR_ST_STOP = 4'h1,
        TMR_ST_FREE = 4'h2,
        TMR_ST_EDGE = 4'h4,
        TMR_ST_MATCH = 4'h8
    } tmr_state_t;

    // static configuration bits
    typedef struct packed {
        logic operating_mode_bit_hi;
        logic operating_mode_bit_lo;
        logic cc0_is_capture;
        logic cc1_is_capture;
        logic [1:0] edge_a_sel;
        logic [1:0] edge_b_sel;
        logic pin_is_output;
    } tmr_cfg_t;

    // software access strobes, one-cycle each except count_rd and cc1_rd
    typedef struct packed {
        logic wr0;
        logic wr1;
        logic [15:0] wdata;
        logic count_rd;
        logic cc0_rd;
        logic cc1_rd;
        logic ovf_clr;
    } tmr_sw_t;
endpackage : tmr_pkg

// File: src/tmr_edge_det.sv
// two-flop synchroniser and valid-edge detector for one timer input pin
`timescale 1ns/1ps
module tmr_edge_det (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    input wire logic [1:0] i_sel,
    output logic o_edge
);
    logic sync1;
    logic sync2;
    logic prev;
    logic next_edge;
    logic [2:0] fill, next_fill;

    // edge is taken between second flop and its delayed copy only
    always_comb begin
        next_edge = 1'b0;
        // no edge until the chain holds real pin samples, else a high pin fakes one
        next_fill = {fill[1:0], 1'b1};
        if (!fill[2]) begin
            next_edge = 1'b0;
        end else if (i_sel == tmr_pkg::EDGE_RISE) begin
            next_edge = sync2 & ~prev;
        end else if (i_sel == tmr_pkg::EDGE_FALL) begin
            next_edge = ~sync2 & prev;
        end else if (i_sel == tmr_pkg::EDGE_BOTH) begin
            next_edge = sync2 ^ prev;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            fill <= 3'h0;
            o_edge <= 1'b0;
        end else begin
            fill <= next_fill;
            sync1 <= i_pin;
            sync2 <= sync1;
            prev <= sync2;
            o_edge <= next_edge;
        end
    end
endmodule : tmr_edge_det

// File: src/tmr_timer16.sv
// 16-bit timer/event counter with two capture/compare registers
`timescale 1ns/1ps
// What this block does
// - counter read never loads second capture register
// - counting pauses while counter is being read
// - zero compare matches on step zero to one
// - compare below count waits through a wrap
// - compare-configured register ignores capture triggers
// - shared pin is edge input or output
// - capture beats a coinciding register read
// - stop during capture drops the queued capture
// - overflow flag set on wrap from all ones
// - capture at count fall, interrupt next rise
// - nonzero mode bits run, zero bits stop
module tmr_timer16 (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire tmr_pkg::tmr_cfg_t i_cfg,
    input wire tmr_pkg::tmr_sw_t i_sw,
    input wire logic i_edge_input_a,
    input wire logic i_shared_port_pin,
    output logic o_shared_port_pin,
    output logic o_shared_port_pin_oe,
    output logic [15:0] o_count_value,
    output logic [15:0] o_cc0_value,
    output logic [15:0] o_cc1_value,
    output logic o_compare_match_irq_a,
    output logic o_compare_match_irq_b,
    output logic o_overflow_flag,
    output logic o_running
);
    tmr_pkg::tmr_state_t state, next_state;
    logic phase, next_phase;
    logic [15:0] count, next_count;
    logic [15:0] cc0, next_cc0;
    logic [15:0] cc1, next_cc1;
    logic pend0, next_pend0;
    logic pend1, next_pend1;
    logic cap_irq0, next_cap_irq0;
    logic cap_irq1, next_cap_irq1;
    logic clr_pend, next_clr_pend;
    logic ovf, next_ovf;
    logic irq_a, next_irq_a;
    logic irq_b, next_irq_b;
    logic tout, next_tout;
    logic pin_oe, next_pin_oe;
    logic active, next_active;
    logic edge_a, edge_b_raw, edge_b;
    logic run, rise, fall, step;
    logic match0, match1;
    logic [1:0] mode_bits;

    ////////////////////////////////////////////////////////////////////////
    // input edges
    tmr_edge_det u_edge_a (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_edge_input_a),
        .i_sel(i_cfg.edge_a_sel),
        .o_edge(edge_a)
    );
    tmr_edge_det u_edge_b (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_shared_port_pin),
        .i_sel(i_cfg.edge_b_sel),
        .o_edge(edge_b_raw)
    );

    // pin driven as output cannot also feed the edge input
    assign edge_b = edge_b_raw & ~pin_oe;

    ////////////////////////////////////////////////////////////////////////
    // count clock phases: rise steps the counter, fall loads captures
    assign mode_bits = {i_cfg.operating_mode_bit_hi, i_cfg.operating_mode_bit_lo};
    assign run = (state != tmr_pkg::TMR_ST_STOP);
    assign rise = run & ~phase;
    assign fall = run & phase;
    assign step = rise & ~i_sw.count_rd;
    // a match is seen on the step that leaves the compare value
    assign match0 = step & (count == cc0) & ~i_cfg.cc0_is_capture;
    assign match1 = step & (count == cc1) & ~i_cfg.cc1_is_capture;

    // operating state follows the mode bits one clock later
    always_comb begin
        next_state = tmr_pkg::TMR_ST_STOP;
        if (mode_bits == tmr_pkg::MODE_FREE) begin
            next_state = tmr_pkg::TMR_ST_FREE;
        end else if (mode_bits == tmr_pkg::MODE_EDGE_CLR) begin
            next_state = tmr_pkg::TMR_ST_EDGE;
        end else if (mode_bits == tmr_pkg::MODE_MATCH_CLR) begin
            next_state = tmr_pkg::TMR_ST_MATCH;
        end
        next_phase = run ? ~phase : 1'b0;
        next_active = (next_state != tmr_pkg::TMR_ST_STOP);
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= tmr_pkg::TMR_ST_STOP;
            phase <= 1'b0;
            active <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            active <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter, overflow and match events
    always_comb begin
        next_count = count;
        next_ovf = ovf;
        next_clr_pend = clr_pend;
        next_irq_a = 1'b0;
        next_irq_b = 1'b0;
        next_tout = tout;
        if (i_sw.ovf_clr) begin
            next_ovf = 1'b0;
        end
        case (state)
            tmr_pkg::TMR_ST_STOP: begin
                next_count = tmr_pkg::CNT_ZERO;
                next_clr_pend = 1'b0;
            end
            default: begin
                if (step) begin
                    if (clr_pend && state == tmr_pkg::TMR_ST_EDGE) begin
                        next_count = tmr_pkg::CNT_ZERO;
                        next_clr_pend = 1'b0;
                    end else if (state == tmr_pkg::TMR_ST_MATCH && count == cc0) begin
                        next_count = tmr_pkg::CNT_ZERO;
                    end else begin
                        // wraps naturally, so a lower compare waits a lap
                        next_count = 16'(count + tmr_pkg::CNT_ONE);
                    end
                    if (count == tmr_pkg::CNT_MAX) begin
                        next_ovf = 1'b1;
                    end
                end
            end
        endcase
        // a new edge on the clearing step is kept, not lost
        if (edge_a && state == tmr_pkg::TMR_ST_EDGE) begin
            next_clr_pend = 1'b1;
        end
        // capture interrupts go out at the rise after the load
        next_irq_a = match0 | (rise & cap_irq0);
        next_irq_b = match1 | (rise & cap_irq1);
        if (match0) begin
            next_tout = ~tout;
        end
        next_pin_oe = i_cfg.pin_is_output;
    end

    // the set wins over a same-cycle software clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            count <= tmr_pkg::CNT_ZERO;
            ovf <= 1'b0;
            clr_pend <= 1'b0;
            irq_a <= 1'b0;
            irq_b <= 1'b0;
            tout <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            count <= next_count;
            ovf <= next_ovf;
            clr_pend <= next_clr_pend;
            irq_a <= next_irq_a;
            irq_b <= next_irq_b;
            tout <= next_tout;
            pin_oe <= next_pin_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture/compare registers
    always_comb begin
        next_cc0 = cc0;
        next_cc1 = cc1;
        next_pend0 = pend0;
        next_pend1 = pend1;
        next_cap_irq0 = cap_irq0 & ~rise;
        next_cap_irq1 = cap_irq1 & ~rise;
        if (i_sw.wr0) begin
            next_cc0 = i_sw.wdata;
        end
        if (i_sw.wr1) begin
            next_cc1 = i_sw.wdata;
        end
        if (fall && pend0) begin
            next_cc0 = count;
            next_pend0 = 1'b0;
            next_cap_irq0 = 1'b1;
        end
        if (fall && pend1) begin
            next_cc1 = count;
            next_pend1 = 1'b0;
            next_cap_irq1 = 1'b1;
        end
        // only real pin edges queue a capture; after the load so a new edge wins
        if (edge_b && i_cfg.cc0_is_capture) begin
            next_pend0 = 1'b1;
        end
        if (edge_a && i_cfg.cc1_is_capture) begin
            next_pend1 = 1'b1;
        end
        // a stop drops queued captures; their result is not defined anyway
        if (!run) begin
            next_pend0 = 1'b0;
            next_pend1 = 1'b0;
            next_cap_irq0 = 1'b0;
            next_cap_irq1 = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cc0 <= tmr_pkg::CC_RST;
            cc1 <= tmr_pkg::CC_RST;
            pend0 <= 1'b0;
            pend1 <= 1'b0;
            cap_irq0 <= 1'b0;
            cap_irq1 <= 1'b0;
        end else begin
            cc0 <= next_cc0;
            cc1 <= next_cc1;
            pend0 <= next_pend0;
            pend1 <= next_pend1;
            cap_irq0 <= next_cap_irq0;
            cap_irq1 <= next_cap_irq1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign o_count_value = count;
    assign o_cc0_value = cc0;
    assign o_cc1_value = cc1;
    assign o_compare_match_irq_a = irq_a;
    assign o_compare_match_irq_b = irq_b;
    assign o_overflow_flag = ovf;
    assign o_shared_port_pin = tout;
    assign o_shared_port_pin_oe = pin_oe;
    assign o_running = active;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_cap1_load;
        fall && pend1 && i_cfg.cc1_is_capture && !i_sw.wr1;
    endsequence
    sequence s_cap_irq_b;
        o_compare_match_irq_b;
    endsequence

    a_read_pauses_count: assert property (
        (rise && i_sw.count_rd && state != tmr_pkg::TMR_ST_STOP && $stable(mode_bits))
        |=> $stable(count)
    ) else $error("counter moved during a read");
    a_stop_clears_count: assert property (
        (mode_bits == tmr_pkg::MODE_STOP)[*2] |=> count == tmr_pkg::CNT_ZERO && !o_running
    ) else $error("stopped counter not cleared");
    a_ovf_on_wrap: assert property (
        step && count == tmr_pkg::CNT_MAX |=> ovf
    ) else $error("overflow flag missed a wrap");
    a_zero_match_step: assert property (
        step && count == tmr_pkg::CNT_ZERO && cc1 == tmr_pkg::CNT_ZERO && !i_cfg.cc1_is_capture
        |=> o_compare_match_irq_b
    ) else $error("zero compare did not match on step to one");
    a_capture_irq_rise: assert property (
        s_cap1_load ##1 rise |=> s_cap_irq_b
    ) else $error("capture interrupt not at next rise");
    a_read_no_capture: assert property (
        $changed(cc1) |-> $past(i_sw.wr1) || $past(fall && pend1)
    ) else $error("second register changed without a capture");
    a_compare_no_capture: assert property (
        $changed(cc0) && !$past(i_cfg.cc0_is_capture) |-> $past(i_sw.wr0) || $past(pend0)
    ) else $error("compare register captured");
    a_pin_exclusive: assert property (
        pin_oe && !pend0 |=> !pend0
    ) else $error("edge input active while pin drives");
    a_capture_priority: assert property (
        fall && pend1 && i_sw.cc1_rd && !i_sw.wr1 |=> cc1 == $past(count)
    ) else $error("read blocked a capture");
    a_ovf_set_wins: assert property (
        step && count == tmr_pkg::CNT_MAX && i_sw.ovf_clr |=> ovf
    ) else $error("clear beat overflow set");
endmodule : tmr_timer16

// File: sim/timer16_capture_compare_tb.sv
// self-checking bench for the 16-bit timer/event counter
`timescale 1ns/1ps
module timer16_capture_compare_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    tmr_pkg::tmr_cfg_t cfg = '0;
    tmr_pkg::tmr_sw_t sw = '0;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    logic pin_out, pin_oe, irq_a, irq_b, ovf, running;
    logic [15:0] cnt, cc0, cc1, mx, c;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int irqs_a, irqs_b;
    // rows as {mode, pin_is_output, expected running, expected oe}
    logic [4:0] rows [4] = '{5'h00, 5'h0F, 5'h12, 5'h1F};

    ////////////////////////////////////////////////////////////////////////////
    // clock and device under test
    always #5 i_ref_clk = ~i_ref_clk;

    tmr_timer16 uut (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_cfg(cfg),
        .i_sw(sw),
        .i_edge_input_a(pin_a),
        .i_shared_port_pin(pin_b),
        .o_shared_port_pin(pin_out),
        .o_shared_port_pin_oe(pin_oe),
        .o_count_value(cnt),
        .o_cc0_value(cc0),
        .o_cc1_value(cc1),
        .o_compare_match_irq_a(irq_a),
        .o_compare_match_irq_b(irq_b),
        .o_overflow_flag(ovf),
        .o_running(running)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers; inputs always move 1 ns after the rising edge
    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t value got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task set_mode(input logic [1:0] m);
        {cfg.operating_mode_bit_hi, cfg.operating_mode_bit_lo} = m;
        tick(1);
    endtask : set_mode

    task wr0(input logic [15:0] d);
        sw.wr0 = 1'b1;
        sw.wdata = d;
        tick(1);
        sw.wr0 = 1'b0;
    endtask : wr0

    // irq pulses last one cycle, so one sample per cycle counts each once
    task watch(input int n);
        irqs_a = 0;
        irqs_b = 0;
        mx = 16'h0000;
        repeat (n) begin
            tick(1);
            if (irq_a === 1'b1) irqs_a++;
            if (irq_b === 1'b1) irqs_b++;
            if (cnt > mx) mx = cnt;
        end
    endtask : watch

    // a hang counts as a mismatch and ends the run
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int k;
        tick(10);
        i_rst_n = 1'b1;
        tick(1);
        chk16(cnt, 16'h0000);
        chk1(running, 1'b0);
        chk1(pin_oe, 1'b0);
        // the match-clear row needs a non-zero compare value
        wr0(16'h0007);
        // mode bits and pin function table
        for (int i = 0; i < 4; i++) begin
            {cfg.operating_mode_bit_hi, cfg.operating_mode_bit_lo, cfg.pin_is_output} = rows[i][4:2];
            tick(3);
            chk1(running, rows[i][1]);
            chk1(pin_oe, rows[i][0]);
        end
        cfg.pin_is_output = 1'b0;
        set_mode(2'h0);
        tick(2);
        chk1(running, 1'b0);
        chk16(cnt, 16'h0000);
        // single match on leaving the compare value
        wr0(16'h0005);
        chk16(cc0, 16'h0005);
        set_mode(2'h1);
        k = 0;
        while (irq_a !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        chk1(irq_a, 1'b1);
        chk16(cnt, 16'h0006);
        chk1(pin_out, 1'b1);
        tick(1);
        chk1(irq_a, 1'b0);
        // compare below count: no match until a wrap, far beyond this window
        wr0(16'h0002);
        watch(60);
        chk16(16'(irqs_a), 16'h0000);
        chk1(ovf, 1'b0);
        // reading the counter freezes it, release resumes counting
        sw.count_rd = 1'b1;
        tick(2);
        c = cnt;
        tick(20);
        chk16(cnt, c);
        sw.count_rd = 1'b0;
        tick(4);
        chk1(cnt != c, 1'b1);
        // match-clear keeps the count within 0..3; stop, write, restart
        set_mode(2'h0);
        wr0(16'h0003);
        set_mode(2'h3);
        watch(40);
        chk16(mx, 16'h0003);
        chk1(irqs_a > 2, 1'b1);
        // compare-configured register ignores a capture edge
        set_mode(2'h0);
        cfg.edge_b_sel = tmr_pkg::EDGE_BOTH;
        wr0(16'h0003);
        set_mode(2'h1);
        pin_b = ~pin_b;
        watch(10);
        chk16(cc0, 16'h0003);
        // pin driven as output: its edges are not taken
        set_mode(2'h0);
        cfg.cc0_is_capture = 1'b1;
        cfg.pin_is_output = 1'b1;
        wr0(16'h0003);
        set_mode(2'h1);
        pin_b = ~pin_b;
        watch(10);
        chk16(16'(irqs_a), 16'h0000);
        chk16(cc0, 16'h0003);
        // pin back to input: a new pin edge now captures
        set_mode(2'h0);
        cfg.pin_is_output = 1'b0;
        set_mode(2'h1);
        tick(4);
        pin_b = ~pin_b;
        watch(10);
        chk16(16'(irqs_a), 16'h0001);
        // counter reads never load the second register
        set_mode(2'h0);
        cfg.cc1_is_capture = 1'b1;
        cfg.edge_a_sel = tmr_pkg::EDGE_RISE;
        set_mode(2'h1);
        tick(6);
        sw.count_rd = 1'b1;
        watch(6);
        sw.count_rd = 1'b0;
        chk16(cc1, 16'h0000);
        chk16(16'(irqs_b), 16'h0000);
        // a real edge does load it, with one interrupt
        pin_a = 1'b1;
        sw.cc1_rd = 1'b1;
        watch(12);
        pin_a = 1'b0;
        sw.cc1_rd = 1'b0;
        chk16(16'(irqs_b), 16'h0001);
        chk1(cc1 != 16'h0000, 1'b1);
        // edge-clear mode restarts the count from zero on a valid edge
        set_mode(2'h2);
        tick(20);
        c = cnt;
        pin_a = 1'b1;
        watch(12);
        chk1(cnt < c, 1'b1);
        // reset in mid-run; the pin held high must not fake an edge after it
        set_mode(2'h1);
        i_rst_n = 1'b0;
        tick(3);
        chk16(cnt, 16'h0000);
        chk16(cc0, 16'h0000);
        chk16(cc1, 16'h0000);
        chk1(running, 1'b0);
        i_rst_n = 1'b1;
        tick(10);
        chk1(running, 1'b1);
        chk16(cc1, 16'h0000);
        set_mode(2'h0);
        tick(2);
        chk1(running, 1'b0);
        chk16(cnt, 16'h0000);
        report_and_stop();
    end
endmodule : timer16_capture_compare_tb
